// ===== verilog/stt_pkg.sv
// Package for the system tick down counter: register map, fields, constants.
// Assumes a single 10 MHz processor clock and a simple word-wide register port.
package stt_pkg;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          COUNT_W         = 24;
    localparam int          DIV_W           = 3;
    localparam logic [2:0]  DIV_LAST        = 3'h7;
    localparam logic [31:0] ADDR_CTRL       = 32'hE000E010;
    localparam logic [31:0] ADDR_RELOAD     = 32'hE000E014;
    localparam logic [31:0] ADDR_CURRENT    = 32'hE000E018;
    localparam logic [31:0] ADDR_CALIB      = 32'hE000E01C;
    localparam int          BIT_ENABLE      = 0;
    localparam int          BIT_REQ_GATE    = 1;
    localparam int          BIT_CLK_SEL     = 2;
    localparam int          BIT_ZERO_FLAG   = 16;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;
    localparam logic [31:0] CALIB_VALUE     = 32'hC0000000;
    localparam logic [23:0] COUNT_ZERO      = 24'h000000;
    localparam logic [23:0] COUNT_ONE       = 24'h000001;
    localparam logic [31:0] READ_ZERO       = 32'h00000000;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic        privileged;
        logic [31:0] addr;
        logic [31:0] wdata;
    } stt_req_t;

    typedef struct packed {
        logic        count_clock_select;
        logic        tick_request_gate;
        logic        enable;
    } stt_ctrl_t;
endpackage

// ===== verilog/stt_timer.sv
// System tick down counter with its four word registers.
// Assumes one-cycle register strobes from the processor, sync to clk.
// Overview of operation
// - 24-bit counter decrements on each enabled tick
// - After zero, reload on next tick
// - Debug halt freezes the counter
// - Bit 16 flag set at zero, read clears
// - Bit 2 selects divided or full clock
// - Bit 1 gates the exception request
// - Enable write loads reload, then counts
// - At zero: flag, gated request, reload
// - Enable low: no count, flag, request
// - Reset clears control register to zero
// - Calibration reads 0xC0000000; others unknown
// - Only privileged accesses are accepted
// - Current value write clears count and flag
// - Reload zero gives no flag or request
`timescale 1ns/10ps
module stt_timer
    import stt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire stt_req_t    req,
    input  wire logic        debug_halt,
    output logic [31:0]      rdata,
    output logic             tick_request
);
    stt_ctrl_t         ctrl;
    logic              zero_flag;
    logic [23:0]       reload;
    logic [23:0]       current;
    logic [DIV_W-1:0]  div_count;
    logic              load_pending;
    logic              tick_en;
    logic              step;
    logic              hit_zero;
    logic              accept;
    logic              wr_ctrl;
    logic              rd_ctrl;
    logic              wr_reload;
    logic              wr_current;
    logic [31:0]       next_rdata;

    function automatic logic hit(input stt_req_t r, input logic [31:0] a, input logic w);
        hit = r.sel && r.privileged && (r.addr == a) && (r.write == w);
    endfunction

    // Register indices into the select vectors
    localparam int          REG_N       = 4;
    localparam int          IDX_CTRL    = 0;
    localparam int          IDX_RELOAD  = 1;
    localparam int          IDX_CURRENT = 2;
    localparam int          IDX_CALIB   = 3;
    localparam logic [31:0] REG_ADDR [REG_N] = '{ADDR_CTRL, ADDR_RELOAD, ADDR_CURRENT, ADDR_CALIB};

    logic [REG_N-1:0]  reg_rd;
    logic [REG_N-1:0]  reg_wr;
    logic              reload_now;
    logic              rd_reload;
    logic              rd_current;
    logic              rd_calib;

    // One decoder per mapped word; unprivileged or unmapped gives no strobe
    for (genvar gi = 0; gi < REG_N; gi++) begin : g_sel
        assign reg_rd[gi] = hit(req, REG_ADDR[gi], 1'b0);
        assign reg_wr[gi] = hit(req, REG_ADDR[gi], 1'b1);
    end

    function automatic logic [31:0] ctrl_word(input stt_ctrl_t c, input logic flag);
        ctrl_word                = READ_ZERO;
        ctrl_word[BIT_ENABLE]    = c.enable;
        ctrl_word[BIT_REQ_GATE]  = c.tick_request_gate;
        ctrl_word[BIT_CLK_SEL]   = c.count_clock_select;
        ctrl_word[BIT_ZERO_FLAG] = flag;
    endfunction

    // Upper byte of the count words always reads zero
    function automatic logic [31:0] count_word(input logic [COUNT_W-1:0] v);
        count_word              = READ_ZERO;
        count_word[COUNT_W-1:0] = v;
    endfunction

    assign accept     = req.sel && req.privileged;
    assign wr_ctrl    = reg_wr[IDX_CTRL];
    assign rd_ctrl    = reg_rd[IDX_CTRL];
    assign wr_reload  = reg_wr[IDX_RELOAD];
    assign wr_current = reg_wr[IDX_CURRENT];
    assign rd_reload  = reg_rd[IDX_RELOAD];
    assign rd_current = reg_rd[IDX_CURRENT];
    // Calibration write strobe is decoded but deliberately has no effect
    assign rd_calib   = reg_rd[IDX_CALIB];
    // Arm or wrap: both reload instead of decrementing
    assign reload_now = load_pending || (current == COUNT_ZERO);

    // Prescaler keeps one clock domain instead of a gated clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    assign tick_en  = ctrl.count_clock_select ? 1'b1 : (div_count == DIV_LAST);
    assign step     = ctrl.enable && !debug_halt && tick_en;
    // Only the one-to-zero step counts as reaching zero
    assign hit_zero = step && !load_pending && (current == COUNT_ONE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
        end else if (wr_ctrl) begin
            ctrl.enable             <= req.wdata[BIT_ENABLE];
            ctrl.tick_request_gate  <= req.wdata[BIT_REQ_GATE];
            ctrl.count_clock_select <= req.wdata[BIT_CLK_SEL];
        end
    end

    // Reload and current have no defined reset value; cleared for determinism
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload <= COUNT_ZERO;
        end else if (wr_reload) begin
            reload <= req.wdata[COUNT_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pending <= 1'b0;
        end else if (wr_ctrl && req.wdata[BIT_ENABLE] && !ctrl.enable) begin
            load_pending <= 1'b1;
        end else if (step) begin
            load_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            current <= COUNT_ZERO;
        end else if (wr_current) begin
            current <= COUNT_ZERO;
        end else if (step) begin
            if (reload_now) begin
                current <= reload;
            end else begin
                current <= current - COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_flag <= 1'b0;
        end else if (hit_zero) begin
            zero_flag <= 1'b1;
        end else if (rd_ctrl || wr_current) begin
            zero_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_request <= 1'b0;
        end else begin
            tick_request <= hit_zero && ctrl.tick_request_gate;
        end
    end

    always_comb begin
        next_rdata = READ_ZERO;
        if (accept && !req.write) begin
            if (rd_ctrl) begin
                next_rdata = ctrl_word(ctrl, zero_flag);
            end else if (rd_reload) begin
                next_rdata = count_word(reload);
            end else if (rd_current) begin
                next_rdata = count_word(current);
            end else if (rd_calib) begin
                next_rdata = CALIB_VALUE;
            end else begin
                next_rdata = READ_ZERO;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= READ_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // stt_timer

// ===== test/stt_checker.sv
// Port assertions for the tick timer.
// Bound to every stt_timer; sees its ports only.
`timescale 1ns/10ps
module stt_checker
    import stt_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire stt_req_t    req,
    input wire logic        debug_halt,
    input wire logic [31:0] rdata,
    input wire logic        tick_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd, wc, div;
    assign rd = req.sel && !req.write && req.privileged;
    assign wc = req.sel && req.write && req.privileged && req.addr == ADDR_CTRL;
    // Tracks the clock choice, since the checker cannot see it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) div <= 1'b1;
        else if (wc) div <= !req.wdata[BIT_CLK_SEL];
    end
    property p_cal; rd && req.addr == ADDR_CALIB |=> rdata == CALIB_VALUE; endproperty
    a_cal: assert property (p_cal) else $error("calibration read wrong");
    property p_ref; req.sel && !req.write && !req.privileged |=> rdata == READ_ZERO; endproperty
    a_ref: assert property (p_ref) else $error("unprivileged read not zero");
    property p_pls; tick_request |=> !tick_request; endproperty
    a_pls: assert property (p_pls) else $error("request longer than a cycle");
    property p_hlt; $past(debug_halt) |-> !tick_request; endproperty
    a_hlt: assert property (p_hlt) else $error("request while halted");
    property p_dis; wc && !req.wdata[BIT_ENABLE] |-> ##2 !tick_request [*8]; endproperty
    a_dis: assert property (p_dis) else $error("request while disabled");
    property p_gat; wc && !req.wdata[BIT_REQ_GATE] |-> ##2 !tick_request [*8]; endproperty
    a_gat: assert property (p_gat) else $error("request while gated off");
    property p_div; div && tick_request |=> !tick_request [*8]; endproperty
    a_div: assert property (p_div) else $error("divided clock too fast");
    property p_flg; tick_request && rd && req.addr == ADDR_CTRL |=> rdata[BIT_ZERO_FLAG]; endproperty
    a_flg: assert property (p_flg) else $error("zero flag missing");
    c_pls: cover property (tick_request);
    c_hlt: cover property (debug_halt [*4]);
    c_div: cover property (div && tick_request);
endmodule // stt_checker
bind stt_timer stt_checker chk_i (.clk(clk), .rst(rst), .req(req), .debug_halt(debug_halt),
    .rdata(rdata), .tick_request(tick_request));

// ===== test/stt_exc_model.sv
// Exception side model: counts tick requests taken.
// Assumes a one-cycle request pulse on clk.
`timescale 1ns/10ps
module stt_exc_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick_request,
    output logic      [15:0] taken
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) taken <= 16'h0000;
        else if (tick_request) taken <= taken + 16'h0001;
    end
endmodule // stt_exc_model

// ===== test/tb_top.sv
// Self-checking bench for the tick timer.
// Assumes the bound checker and the request counting model.
`timescale 1ns/10ps
module tb_top;
    import stt_pkg::*;
    logic        clk, rst, debug_halt, tick_request;
    stt_req_t    req;
    logic [31:0] rdata;
    logic [15:0] taken, base;
    int          failures, comparisons, cyc;
    stt_timer DUT (.clk(clk), .rst(rst), .req(req), .debug_halt(debug_halt), .rdata(rdata),
        .tick_request(tick_request));
    stt_exc_model exc (.clk(clk), .rst(rst), .tick_request(tick_request), .taken(taken));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Called at a falling edge; strobe stays up for a following access, idle drops it
    task acc(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
        req = '{1'b1, w, p, a, d};
        @(negedge clk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        acc(1'b1, 1'b1, a, d);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp);
        acc(1'b0, 1'b1, a, 32'h00000000);
        chk(rdata, exp);
    endtask
    task idle(input int n);
        req.sel = 1'b0;
        repeat (n) @(negedge clk);
    endtask
    task stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1500) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        debug_halt = 1'b0;
        req = '0;
        idle(2);
        rst = 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        wr(ADDR_CALIB, 32'h00001234);
        rd(ADDR_CALIB, CALIB_VALUE);
        acc(1'b0, 1'b0, ADDR_CTRL, 32'h00000000);
        chk(rdata, READ_ZERO);
        rd(32'hE000E020, READ_ZERO);
        wr(ADDR_RELOAD, 32'h00000005);
        wr(ADDR_CURRENT, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000007);
        idle(60);
        rd(ADDR_CTRL, 32'h00010007);
        rd(ADDR_CTRL, 32'h00000007);
        chk({16'h0000, taken}, 32'h0000000A);
        debug_halt = 1'b1;
        idle(2);
        base = taken;
        idle(30);
        chk({16'h0000, taken - base}, 32'h00000000);
        debug_halt = 1'b0;
        wr(ADDR_CTRL, 32'h00000005);
        idle(2);
        base = taken;
        idle(30);
        chk({16'h0000, taken - base}, 32'h00000000);
        rd(ADDR_CTRL, 32'h00010005);
        wr(ADDR_CTRL, 32'h00000003);
        base = taken;
        idle(481);
        chk({16'h0000, taken - base}, 32'h0000000A);
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_CURRENT, 32'h00ABCDEF);
        rd(ADDR_CTRL, 32'h00000000);
        rd(ADDR_CURRENT, 32'h00000000);
        idle(3);
        rd(ADDR_CURRENT, 32'h00000000);
        wr(ADDR_RELOAD, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000007);
        base = taken;
        idle(30);
        chk({16'h0000, taken - base}, 32'h00000000);
        rd(ADDR_CTRL, 32'h00000007);
        stop_test();
    end
endmodule // tb_top
